/* File: exec_pkg.sv */
// Package of constants and types for the instruction execution subset.
//
// Overview of operation
// - Clear-accumulator op loads zero into accumulator and sets zero flag.
// - Call loads its 8-bit literal into program counter bits 7 to 0.
// - Call pushes current program counter plus one onto the stack first.
// - Call takes counter bits 10:9 from status bits 6:5, clears bit 8.
// - Call takes two instruction cycles and leaves status flags unchanged.
// - Watchdog clear zeroes counter, and prescaler only when assigned to watchdog.
// - Watchdog clear sets active-low time-out and power-down flags to one.
// - Clear-register op writes zero to file register 0..31 and sets zero flag.
// - Destination bit 0 sends result to accumulator, 1 back to the register.
// - Complement op yields bitwise inverse; only zero flag affected.
// - Decrement op yields register minus one; only zero flag affected.
// - Increment op yields register plus one; only zero flag affected.
`default_nettype none

package exec_pkg;

  // ---------------------------------------------------------------------
  // Widths and status bit positions
  // ---------------------------------------------------------------------
  localparam int DATA_W       = 8;
  localparam int PC_W         = 11;
  localparam int FILE_AW      = 5;
  localparam int WDT_W        = 8;
  localparam int PRE_W        = 8;
  localparam int STACK_DEPTH  = 2;
  localparam int ST_CARRY     = 0;
  localparam int ST_DCARRY    = 1;
  localparam int ST_ZERO      = 2;
  localparam int ST_PD_N      = 3;
  localparam int ST_TO_N      = 4;
  localparam int ST_PAGE_LO   = 5;
  localparam int ST_PAGE_HI   = 6;
  localparam int CALL_CYCLES  = 2;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [7:0]  STATUS_RST = 8'h18;
  localparam logic [7:0]  ACC_RST    = 8'h00;
  localparam logic [10:0] PC_RST     = 11'h000;

  // Operation codes presented on the decoded-operation port.
  typedef enum logic [2:0] {
    OP_NONE        = 3'h0,
    OP_CLR_ACC     = 3'h1,
    OP_CALL        = 3'h3,
    OP_WDT_CLR     = 3'h2,
    OP_CLR_REG     = 3'h6,
    OP_COMP_REG    = 3'h7,
    OP_DEC_REG     = 3'h5,
    OP_INC_REG     = 3'h4
  } op_t;

  // Call sequencer states, Gray coded.
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_CALL2  = 2'b01
  } seq_t;

endpackage

`default_nettype wire

/* File: call_stack.sv */
// Return address stack for the subroutine call, held in flip-flops.
`default_nettype none

module call_stack
  import exec_pkg::*;
#(
  parameter int DEPTH = exec_pkg::STACK_DEPTH
)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Push and pop
  input  wire logic             push,
  input  wire logic [PC_W-1:0]  push_addr,
  input  wire logic             pop,
  // Top entry
  output logic      [PC_W-1:0]  top_addr
);

  // Elaboration refuses a stack with no entry, as the shift logic needs one.
  if (DEPTH < 1)
  begin : g_depth_check
    $error("call_stack needs at least one entry");
  end

  logic [PC_W-1:0] entry_q [DEPTH];

  // A push shifts every entry down; the oldest falls off, as a small stack overflows silently.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        entry_q[i] <= PC_RST;
      end
    end
    else if (push)
    begin
      entry_q[0] <= push_addr;
      for (int i = 1; i < DEPTH; i++)
      begin
        entry_q[i] <= entry_q[i-1];
      end
    end
    else if (pop)
    begin
      for (int i = 0; i < DEPTH - 1; i++)
      begin
        entry_q[i] <= entry_q[i+1];
      end
    end
  end

  assign top_addr = entry_q[0];

endmodule

`default_nettype wire

/* File: instr_exec.sv */
// Execution unit for the clear, call, watchdog-clear and file-register update operations.
`default_nettype none

module instr_exec
  import exec_pkg::*;
#(
  parameter int NUM_FILES = 32
)
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  // Decoded instruction
  input  wire logic                 instr_valid,
  input  wire exec_pkg::op_t        instr_op,
  input  wire logic [4:0]           instr_file,
  input  wire logic                 instr_dest,
  input  wire logic [7:0]           instr_literal,
  // Configuration
  input  wire logic                 prescaler_to_wdt,
  // Status and core state
  output logic                      instr_ready,
  output logic [7:0]                acc,
  output logic [7:0]                status,
  output logic [10:0]               pc,
  output logic [10:0]               stack_top,
  output logic [7:0]                watchdog_counter,
  output logic [7:0]                prescaler,
  output logic [7:0]                file_rd_data
);

  // Elaboration refuses register counts that the five-bit address cannot reach.
  if (NUM_FILES < 1 || NUM_FILES > 32)
  begin : g_files_check
    $error("instr_exec serves 1 to 32 file registers");
  end

  // -----------------------------------------------------------------------
  // State
  // -----------------------------------------------------------------------
  logic [7:0]  acc_q, acc_d;
  logic [7:0]  status_q;
  logic [10:0] pc_q;
  logic [7:0]  wdt_q;
  logic [7:0]  pre_q;
  logic [7:0]  file_q [NUM_FILES];
  seq_t        seq_q;
  logic [7:0]  src;
  logic [7:0]  result;
  logic        take;
  logic        push;

  // Zero test shared by the complement, decrement and increment operations.
  function automatic logic is_zero(input logic [7:0] v);
    return (v == 8'h00);
  endfunction

  // Unmapped file addresses read as zero rather than indexing past the array.
  assign src  = (int'(instr_file) < NUM_FILES) ? file_q[instr_file] : 8'h00;
  assign take = instr_valid && (seq_q == ST_IDLE);
  assign push = take && (instr_op == OP_CALL);
  assign instr_ready = (seq_q == ST_IDLE);

  // -----------------------------------------------------------------------
  // Arithmetic result
  // -----------------------------------------------------------------------
  // Only the low eight bits are kept, so increment and decrement wrap.
  always_comb
  begin
    result = 8'h00;
    case (instr_op)
      OP_COMP_REG: result = ~src;
      OP_DEC_REG:  result = src - 8'h01;
      OP_INC_REG:  result = src + 8'h01;
      default:     result = 8'h00;
    endcase
  end

  // Next accumulator value.
  always_comb
  begin
    acc_d = acc_q;
    if (take)
    begin
      case (instr_op)
        OP_CLR_ACC: acc_d = 8'h00;
        OP_COMP_REG,
        OP_DEC_REG,
        OP_INC_REG:
        begin
          if (!instr_dest)
          begin
            acc_d = result;
          end
        end
        default: acc_d = acc_q;
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------------
  // Accumulator.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      acc_q <= ACC_RST;
    else
      acc_q <= acc_d;
  end

  // File registers written back by clear and the destination-one forms.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < NUM_FILES; i++)
      begin
        file_q[i] <= 8'h00;
      end
    end
    else if (take && int'(instr_file) < NUM_FILES)
    begin
      case (instr_op)
        OP_CLR_REG: file_q[instr_file] <= 8'h00;
        OP_COMP_REG,
        OP_DEC_REG,
        OP_INC_REG:
        begin
          if (instr_dest)
          begin
            file_q[instr_file] <= result;
          end
        end
        default: ;
      endcase
    end
  end

  // Status flags; a call touches none of them, carries are never written here.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      status_q <= STATUS_RST;
    else if (take)
    begin
      case (instr_op)
        OP_CLR_ACC,
        OP_CLR_REG: status_q[ST_ZERO] <= 1'b1;
        OP_COMP_REG,
        OP_DEC_REG,
        OP_INC_REG: status_q[ST_ZERO] <= is_zero(result);
        OP_WDT_CLR:
        begin
          status_q[ST_TO_N] <= 1'b1;
          status_q[ST_PD_N] <= 1'b1;
        end
        default: ;
      endcase
    end
  end

  // Watchdog counter and prescaler; they free-run between clears.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wdt_q <= 8'h00;
      pre_q <= 8'h00;
    end
    else if (take && instr_op == OP_WDT_CLR)
    begin
      wdt_q <= 8'h00;
      pre_q <= prescaler_to_wdt ? 8'h00 : pre_q + 8'h01;
    end
    else
    begin
      pre_q <= pre_q + 8'h01;
      if (!prescaler_to_wdt || pre_q == 8'hFF)
        wdt_q <= wdt_q + 8'h01;
    end
  end

  // Program counter: a call jumps to the page-composed target; others except OP_NONE advance by one.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      pc_q <= PC_RST;
    else if (push)
      pc_q <= {status_q[ST_PAGE_HI:ST_PAGE_LO], 1'b0, instr_literal};
    else if (take && instr_op != OP_NONE)
      pc_q <= pc_q + 11'h001;
  end

  // The call holds off the next instruction for its second cycle.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      seq_q <= ST_IDLE;
    else if (push)
      seq_q <= ST_CALL2;
    else
      seq_q <= ST_IDLE;
  end

  // Return address is pushed in the same edge that redirects the counter.
  call_stack #(
    .DEPTH     (STACK_DEPTH)
  ) u_stack (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .push      (push),
    .push_addr (pc_q + 11'h001),
    .pop       (1'b0),
    .top_addr  (stack_top)
  );

  assign acc              = acc_q;
  assign status           = status_q;
  assign pc               = pc_q;
  assign watchdog_counter = wdt_q;
  assign prescaler        = pre_q;
  assign file_rd_data     = src;

endmodule

`default_nettype wire

/* File: instr_exec_assertions.sv */
// Checker for the execution unit, bound to its ports.
`default_nettype none
module instr_exec_chk
  import exec_pkg::*;
#(
  parameter int NUM_FILES = 32
)
(
  // Clock and reset
  input wire logic         clk,
  input wire logic         sys_rst,
  // Decoded instruction
  input wire logic         instr_valid,
  input wire op_t          instr_op,
  input wire logic [4:0]   instr_file,
  input wire logic         instr_dest,
  input wire logic [7:0]   instr_literal,
  input wire logic         prescaler_to_wdt,
  // Core state
  input wire logic         instr_ready,
  input wire logic [7:0]   acc,
  input wire logic [7:0]   status,
  input wire logic [10:0]  pc,
  input wire logic [10:0]  stack_top,
  input wire logic [7:0]   watchdog_counter,
  input wire logic [7:0]   prescaler,
  input wire logic [7:0]   file_rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // An instruction counts only on an edge where the unit is ready.
  wire logic tk = instr_valid && instr_ready;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_clr_acc: assert property (tk && instr_op == OP_CLR_ACC |=> acc == 8'h00 && status[ST_ZERO])
    else $error("clear accumulator wrong");
  a_call_target: assert property (tk && instr_op == OP_CALL |=>
    pc == {$past(status[6:5]), 1'b0, $past(instr_literal)}) else $error("call target wrong");
  a_call_push: assert property (tk && instr_op == OP_CALL |=> stack_top == $past(pc) + 11'h001)
    else $error("return address wrong");
  a_call_two: assert property (tk && instr_op == OP_CALL |=>
    !instr_ready && status == $past(status) ##1 instr_ready) else $error("call timing wrong");
  a_wdt_clear: assert property (tk && instr_op == OP_WDT_CLR |=>
    watchdog_counter == 8'h00 && status[4:3] == 2'b11) else $error("watchdog clear wrong");
  a_pre_clear: assert property (tk && instr_op == OP_WDT_CLR && prescaler_to_wdt |=> prescaler == 8'h00)
    else $error("prescaler not cleared");
  a_reg_clear: assert property (tk && instr_op == OP_CLR_REG |=> status[ST_ZERO] &&
    (instr_file != $past(instr_file) || file_rd_data == 8'h00)) else $error("register clear wrong");
  a_comp_file: assert property (tk && instr_op == OP_COMP_REG && instr_dest |=> acc == $past(acc) &&
    (instr_file != $past(instr_file) || file_rd_data == ~$past(file_rd_data))) else $error("complement wrong");
  a_inc_acc: assert property (tk && instr_op == OP_INC_REG && !instr_dest |=>
    acc == $past(file_rd_data) + 8'h01 && status[ST_ZERO] == (acc == 8'h00)) else $error("increment wrong");
  a_dec_acc: assert property (tk && instr_op == OP_DEC_REG && !instr_dest |=>
    acc == $past(file_rd_data) - 8'h01) else $error("decrement wrong");
  a_carry_keep: assert property (tk && instr_op inside {OP_COMP_REG, OP_DEC_REG, OP_INC_REG} |=>
    status[1:0] == $past(status[1:0])) else $error("carry bits changed");
  // Scenario coverage.
  c_call: cover property (tk && instr_op == OP_CALL);
  c_wdt: cover property (tk && instr_op == OP_WDT_CLR && prescaler_to_wdt);
  c_refuse: cover property (instr_valid && !instr_ready);
endmodule
bind instr_exec instr_exec_chk #(.NUM_FILES(NUM_FILES)) u_chk (.clk(clk), .sys_rst(sys_rst),
  .instr_valid(instr_valid), .instr_op(instr_op), .instr_file(instr_file), .instr_dest(instr_dest),
  .instr_literal(instr_literal), .prescaler_to_wdt(prescaler_to_wdt), .instr_ready(instr_ready), .acc(acc),
  .status(status), .pc(pc), .stack_top(stack_top), .watchdog_counter(watchdog_counter),
  .prescaler(prescaler), .file_rd_data(file_rd_data));
`default_nettype wire

/* File: tb_top.sv */
// Self-checking testbench for the execution unit.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import exec_pkg::*;
  logic        clk, sys_rst, vld, ds, pw, rdy;
  op_t         op;
  logic [4:0]  fl;
  logic [7:0]  lit, acc, st, wd, pre, rd;
  logic [10:0] pc, stk, epc;
  int          failures, num_checks;
  instr_exec dut (.clk(clk), .sys_rst(sys_rst), .instr_valid(vld), .instr_op(op), .instr_file(fl),
    .instr_dest(ds), .instr_literal(lit), .prescaler_to_wdt(pw), .instr_ready(rdy), .acc(acc),
    .status(st), .pc(pc), .stack_top(stk), .watchdog_counter(wd), .prescaler(pre), .file_rd_data(rd));
  // ----------------------------------------
  // Clock, helpers and closing
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Compare a seen value with the expected one.
  task automatic chk(string n, logic [10:0] s, logic [10:0] e);
    num_checks++;
    if (s !== e)
    begin
      failures++;
      $display("[FAIL] %s exp %0h got %0h", n, e, s);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // One instruction, then an idle cycle so a call never meets a follower.
  task automatic go(op_t o, logic [4:0] f, logic d);
    @(posedge clk);
    vld <= 1'b1;
    op <= o;
    fl <= f;
    ds <= d;
    @(posedge clk);
    vld <= 1'b0;
    epc = epc + 11'h001;
    #1;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_acc();
    go(OP_INC_REG, 5'h00, 1'b0);
    chk("inc acc", acc, 8'h01);
    chk("inc st", st, 8'h18);
    chk("file kept", rd, 8'h00);
    go(OP_CLR_ACC, 5'h00, 1'b0);
    chk("clear_accumulator_op acc", acc, 8'h00);
    chk("clear_accumulator_op st", st, 8'h1C);
  endtask
  // Register 31 walks through wrap and zero boundaries.
  task automatic t_file();
    go(OP_INC_REG, 5'h1F, 1'b1);
    go(OP_INC_REG, 5'h1F, 1'b1);
    chk("inc f", rd, 8'h02);
    go(OP_DEC_REG, 5'h1F, 1'b1);
    go(OP_DEC_REG, 5'h1F, 1'b1);
    chk("dec f", rd, 8'h00);
    chk("dec z", st, 8'h1C);
    go(OP_DEC_REG, 5'h1F, 1'b0);
    chk("dec acc", acc, 8'hFF);
    chk("dec nz", st, 8'h18);
    go(OP_COMP_REG, 5'h1F, 1'b1);
    chk("comp f", rd, 8'hFF);
    go(OP_INC_REG, 5'h1F, 1'b1);
    chk("inc wrap", rd, 8'h00);
    chk("wrap z", st, 8'h1C);
    go(OP_COMP_REG, 5'h1F, 1'b1);
    chk("comp nz", st, 8'h18);
    go(OP_CLR_REG, 5'h1F, 1'b0);
    chk("clear_register_op f", rd, 8'h00);
    chk("clear_register_op z", st, 8'h1C);
  endtask
  // A follower held on during the second call cycle must be ignored.
  task automatic t_call();
    @(posedge clk);
    vld <= 1'b1;
    op <= OP_CALL;
    lit <= 8'hFF;
    @(posedge clk);
    op <= OP_INC_REG;
    fl <= 5'h00;
    ds <= 1'b0;
    #1;
    chk("call rdy", rdy, 1'b0);
    chk("call pc", pc, 11'h0FF);
    chk("push", stk, epc + 11'h001);
    chk("call st", st, 8'h1C);
    @(posedge clk);
    vld <= 1'b0;
    #1;
    chk("rdy back", rdy, 1'b1);
    chk("refused", acc, 8'hFF);
    epc = 11'h0FF;
    go(OP_INC_REG, 5'h00, 1'b1);
    go(OP_CALL, 5'h00, 1'b0);
    chk("pc8 clr", pc, 11'h0FF);
    chk("push hi", stk, 11'h101);
  endtask
  // Watchdog clear with the prescaler on the timer, then on the watchdog.
  task automatic t_wdt();
    go(OP_WDT_CLR, 5'h00, 1'b0);
    chk("wdt", wd, 8'h00);
    chk("pre kept", pre == 8'h00, 1'b0);
    chk("to pd", st[4:3], 2'b11);
    @(posedge clk);
    pw <= 1'b1;
    #1;
    chk("wdt runs", wd, 8'h01);
    repeat (5) @(posedge clk);
    #1;
    chk("wdt held", wd, 8'h01);
    go(OP_WDT_CLR, 5'h00, 1'b0);
    chk("pre", pre, 8'h00);
    chk("wdt2", wd, 8'h00);
    repeat (3) @(posedge clk);
    #1;
    chk("pre runs", pre, 8'h03);
    chk("wdt2 held", wd, 8'h00);
  endtask
  // Main sequence; the call literal stays at FF for the second call.
  initial
  begin
    sys_rst = 1'b1;
    vld = 1'b0;
    op = OP_NONE;
    fl = 5'h00;
    ds = 1'b0;
    lit = 8'h00;
    pw = 1'b0;
    epc = 11'h000;
    failures = 0;
    num_checks = 0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk("rst st", st, 8'h18);
    chk("rst pc", pc, 11'h000);
    t_acc();
    t_file();
    t_call();
    t_wdt();
    end_sim();
  end
  // The run needs about fifty cycles; this limit only catches a hang.
  initial
  begin
    #100000;
    failures++;
    end_sim();
  end
endmodule
`default_nettype wire
